// ===== design/tile_status_debug_regs.sv
// Processor-status register bank of one processor tile
`timescale 1ns/1ps
`default_nettype none

module tile_status_debug_regs #(
	parameter int          OSC_W       = tile_status_pkg::OSC_COUNT_W,
	parameter logic [31:0] RAM_BYTES   = 32'h0008_0000
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic        clk_en,
	// Status register port
	input  wire logic        ps_read,
	input  wire logic        ps_write,
	input  wire logic [7:0]  ps_num,
	input  wire logic [31:0] ps_wdata,
	input  wire logic        ps_debug_mode,
	input  wire logic        ps_from_jtag,
	output logic [31:0]      ps_rdata,
	output logic             ps_ack,
	output logic             ps_refused,
	// Boot straps and tile state
	input  wire logic [1:0]  boot_pll_mode_pins,
	input  wire logic        boot_from_ram,
	input  wire logic        boot_from_jtag,
	input  wire logic        boot_no_otp_poll,
	input  wire logic        core1_powered_off,
	input  wire logic        boot_mode_override,
	input  wire logic [7:0]  processor_number,
	// Security load from OTP
	input  wire logic        otp_sec_valid,
	input  wire logic [31:0] otp_sec_word,
	// Security outputs
	output logic [3:0]       otp_sector_lock,
	output logic             otp_lock_all,
	output logic             otp_redundancy_en,
	output logic             otp_force_boot,
	output logic             jtag_cfg_block,
	output logic             jtag_tap_block,
	output logic             global_debug_block,
	// Ring oscillator interface
	output logic             core_osc_en,
	output logic             periph_osc_en,
	input  wire logic [OSC_W-1:0] osc_count_tile_cell,
	input  wire logic [OSC_W-1:0] osc_count_tile_wire,
	input  wire logic [OSC_W-1:0] osc_count_periph_cell,
	input  wire logic [OSC_W-1:0] osc_count_periph_wire,
	// Debug entry capture
	input  wire logic        debug_entry,
	input  wire logic [31:0] thread_status,
	input  wire logic [31:0] thread_pc,
	input  wire logic [31:0] thread_sp
);

	// Package constants used by the bank
	localparam REG_TILE_BOOT_STATE        = tile_status_pkg::REG_TILE_BOOT_STATE;
	localparam REG_SECURITY_LOCK_CONFIG   = tile_status_pkg::REG_SECURITY_LOCK_CONFIG;
	localparam REG_RING_OSC_ENABLE        = tile_status_pkg::REG_RING_OSC_ENABLE;
	localparam REG_RING_COUNT_TILE_CELL   = tile_status_pkg::REG_RING_COUNT_TILE_CELL;
	localparam REG_RING_COUNT_TILE_WIRE   = tile_status_pkg::REG_RING_COUNT_TILE_WIRE;
	localparam REG_RING_COUNT_PERIPH_CELL = tile_status_pkg::REG_RING_COUNT_PERIPH_CELL;
	localparam REG_RING_COUNT_PERIPH_WIRE = tile_status_pkg::REG_RING_COUNT_PERIPH_WIRE;
	localparam REG_RAM_BYTE_SIZE          = tile_status_pkg::REG_RAM_BYTE_SIZE;
	localparam REG_DEBUG_SAVED_STATUS     = tile_status_pkg::REG_DEBUG_SAVED_STATUS;
	localparam REG_DEBUG_SAVED_PC         = tile_status_pkg::REG_DEBUG_SAVED_PC;
	localparam REG_DEBUG_SAVED_STACK_PTR  = tile_status_pkg::REG_DEBUG_SAVED_STACK_PTR;
	localparam REG_DEBUG_FETCH_THREAD_SEL = tile_status_pkg::REG_DEBUG_FETCH_THREAD_SEL;
	localparam REG_DEBUG_FETCH_REG_SEL    = tile_status_pkg::REG_DEBUG_FETCH_REG_SEL;
	localparam BOOT_PLL_MODE_LSB          = tile_status_pkg::BOOT_PLL_MODE_LSB;
	localparam BOOT_FROM_JTAG_BIT         = tile_status_pkg::BOOT_FROM_JTAG_BIT;
	localparam BOOT_FROM_RAM_BIT          = tile_status_pkg::BOOT_FROM_RAM_BIT;
	localparam BOOT_NO_OTP_POLL           = tile_status_pkg::BOOT_NO_OTP_POLL;
	localparam BOOT_CORE1_OFF_BIT         = tile_status_pkg::BOOT_CORE1_OFF_BIT;
	localparam BOOT_OVERRIDE_BIT          = tile_status_pkg::BOOT_OVERRIDE_BIT;
	localparam BOOT_PROC_NUM_LSB          = tile_status_pkg::BOOT_PROC_NUM_LSB;
	localparam SEC_JTAG_TAP_OFF           = tile_status_pkg::SEC_JTAG_TAP_OFF;
	localparam SEC_JTAG_CFG_OFF           = tile_status_pkg::SEC_JTAG_CFG_OFF;
	localparam SEC_OTP_BOOT               = tile_status_pkg::SEC_OTP_BOOT;
	localparam SEC_OTP_REDUND             = tile_status_pkg::SEC_OTP_REDUND;
	localparam SEC_SECTOR_LSB             = tile_status_pkg::SEC_SECTOR_LSB;
	localparam SEC_ALL_SECTORS            = tile_status_pkg::SEC_ALL_SECTORS;
	localparam SEC_GLOBAL_DBG             = tile_status_pkg::SEC_GLOBAL_DBG;
	localparam SEC_WRITE_LOCK             = tile_status_pkg::SEC_WRITE_LOCK;
	localparam SEC_WRITABLE_MASK          = tile_status_pkg::SEC_WRITABLE_MASK;
	localparam OSC_PERIPH_EN_BIT          = tile_status_pkg::OSC_PERIPH_EN_BIT;
	localparam OSC_CORE_EN_BIT            = tile_status_pkg::OSC_CORE_EN_BIT;
	localparam SAVED_STATUS_WR_MASK       = tile_status_pkg::SAVED_STATUS_WR_MASK;
	localparam SAVED_STATUS_MASK          = tile_status_pkg::SAVED_STATUS_MASK;
	localparam STATUS_ISSUE_MODE_BIT      = tile_status_pkg::STATUS_ISSUE_MODE_BIT;
	localparam THREAD_SEL_W               = tile_status_pkg::THREAD_SEL_W;
	localparam REG_SEL_W                  = tile_status_pkg::REG_SEL_W;
	localparam RAM_SIZE_MASK              = tile_status_pkg::RAM_SIZE_MASK;

	typedef struct packed {
		logic [3:0]  strap_sync1;
		logic [3:0]  strap_sync2;
		logic [31:0] boot_state;
		logic [31:0] security;
		logic        sec_loaded;
		logic [1:0]  osc_en;
		logic [31:0] saved_status;
		logic [31:0] saved_pc;
		logic [31:0] saved_sp;
		logic [7:0]  thread_sel;
		logic [4:0]  reg_sel;
		logic [31:0] rdata;
		logic        ack;
		logic        refused;
	} state_s;

	state_s st_q;
	state_s st_d;

	// Counter snapshots from the oscillator domain
	logic [OSC_W-1:0] cnt_meta_q [4];
	logic [OSC_W-1:0] cnt_sync_q [4];

	function automatic logic [31:0] pad_count(input logic [OSC_W-1:0] v);
		pad_count = 32'h0;
		pad_count[OSC_W-1:0] = v;
	endfunction

	// Counters are never reset, so their values survive a system reset
	// Bits cross one by one; a count is only whole once its oscillator stops
	// no reset
	always_ff @(posedge clock) begin
		if (clk_en) begin
			cnt_meta_q[0] <= osc_count_tile_cell;
			cnt_meta_q[1] <= osc_count_tile_wire;
			cnt_meta_q[2] <= osc_count_periph_cell;
			cnt_meta_q[3] <= osc_count_periph_wire;
			cnt_sync_q    <= cnt_meta_q;
		end
	end

	logic sec_we;
	logic cfg_jtag_refuse;

	always_comb begin
		st_d = st_q;
		st_d.ack = 1'b0;
		st_d.refused = 1'b0;
		// Pin straps pass two flops before anything reads them
		st_d.strap_sync1 = {boot_from_ram, boot_from_jtag, boot_pll_mode_pins};
		st_d.strap_sync2 = st_q.strap_sync1;
		st_d.boot_state = 32'h0;
		st_d.boot_state[BOOT_PROC_NUM_LSB +: 8] = processor_number;
		st_d.boot_state[BOOT_PLL_MODE_LSB +: 2] = st_q.strap_sync2[1:0];
		st_d.boot_state[BOOT_FROM_RAM_BIT]  = st_q.strap_sync2[3];
		st_d.boot_state[BOOT_FROM_JTAG_BIT] = st_q.strap_sync2[2];
		st_d.boot_state[BOOT_NO_OTP_POLL]   = boot_no_otp_poll;
		st_d.boot_state[BOOT_CORE1_OFF_BIT] = core1_powered_off;
		st_d.boot_state[BOOT_OVERRIDE_BIT]  = boot_mode_override;

		if (otp_sec_valid && !st_q.sec_loaded) begin
			st_d.security   = otp_sec_word & SEC_WRITABLE_MASK;
			st_d.sec_loaded = 1'b1;
		end

		if (debug_entry) begin
			st_d.saved_status = thread_status & SAVED_STATUS_MASK;
			st_d.saved_pc = thread_pc;
			st_d.saved_sp = thread_sp;
		end

		if (ps_write || ps_read) begin
			st_d.ack = 1'b1;
			st_d.refused = cfg_jtag_refuse;
		end

		if (ps_write && !cfg_jtag_refuse) begin
			unique case (ps_num)
				REG_SECURITY_LOCK_CONFIG: begin
					if (sec_we) begin
						st_d.security = ps_wdata & SEC_WRITABLE_MASK;
					end
				end
				REG_RING_OSC_ENABLE: begin
					st_d.osc_en = ps_wdata[1:0];
				end
				REG_DEBUG_SAVED_STATUS: begin
					if (ps_debug_mode) begin
						st_d.saved_status = (ps_wdata & SAVED_STATUS_WR_MASK)
							| (st_q.saved_status & ~SAVED_STATUS_WR_MASK);
					end
				end
				REG_DEBUG_SAVED_PC: begin
					if (ps_debug_mode) begin
						st_d.saved_pc = ps_wdata;
					end
				end
				REG_DEBUG_SAVED_STACK_PTR: begin
					if (ps_debug_mode) begin
						st_d.saved_sp = ps_wdata;
					end
				end
				REG_DEBUG_FETCH_THREAD_SEL: begin
					if (ps_debug_mode) begin
						st_d.thread_sel = ps_wdata[THREAD_SEL_W-1:0];
					end
				end
				REG_DEBUG_FETCH_REG_SEL: begin
					if (ps_debug_mode) begin
						st_d.reg_sel = ps_wdata[REG_SEL_W-1:0];
					end
				end
				default: begin
					st_d.rdata = st_q.rdata;
				end
			endcase
		end

		if (ps_read) begin
			st_d.rdata = 32'h0;
			if (!cfg_jtag_refuse) begin
				unique case (ps_num)
					REG_TILE_BOOT_STATE:        st_d.rdata = st_q.boot_state;
					REG_SECURITY_LOCK_CONFIG:   st_d.rdata = st_q.security;
					REG_RING_OSC_ENABLE:        st_d.rdata = {30'h0, st_q.osc_en};
					REG_RING_COUNT_TILE_CELL:   st_d.rdata = pad_count(cnt_sync_q[0]);
					REG_RING_COUNT_TILE_WIRE:   st_d.rdata = pad_count(cnt_sync_q[1]);
					REG_RING_COUNT_PERIPH_CELL: st_d.rdata = pad_count(cnt_sync_q[2]);
					REG_RING_COUNT_PERIPH_WIRE: st_d.rdata = pad_count(cnt_sync_q[3]);
					REG_RAM_BYTE_SIZE:          st_d.rdata = RAM_BYTES & RAM_SIZE_MASK;
					REG_DEBUG_SAVED_STATUS:     st_d.rdata = st_q.saved_status;
					REG_DEBUG_SAVED_PC:         st_d.rdata = st_q.saved_pc;
					REG_DEBUG_SAVED_STACK_PTR:  st_d.rdata = st_q.saved_sp;
					REG_DEBUG_FETCH_THREAD_SEL: st_d.rdata = {24'h0, st_q.thread_sel};
					REG_DEBUG_FETCH_REG_SEL:    st_d.rdata = {27'h0, st_q.reg_sel};
					default:                    st_d.rdata = 32'h0;
				endcase
			end
		end
	end

	assign sec_we = !st_q.security[SEC_WRITE_LOCK];
	assign cfg_jtag_refuse = ps_from_jtag && st_q.security[SEC_JTAG_CFG_OFF]
		&& (ps_num == REG_TILE_BOOT_STATE || ps_num == REG_SECURITY_LOCK_CONFIG);

	always_ff @(posedge clock) begin
		if (srst) begin
			st_q <= '0;
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	assign otp_sector_lock    = st_q.security[SEC_SECTOR_LSB +: 4];
	assign otp_lock_all       = st_q.security[SEC_ALL_SECTORS];
	assign otp_force_boot     = st_q.security[SEC_OTP_BOOT];
	assign otp_redundancy_en  = st_q.security[SEC_OTP_REDUND];
	assign jtag_cfg_block     = st_q.security[SEC_JTAG_CFG_OFF];
	assign global_debug_block = st_q.security[SEC_GLOBAL_DBG];
	assign jtag_tap_block     = st_q.security[SEC_JTAG_TAP_OFF];
	// oscillators run on their own clocks while their enable bits are set
	assign core_osc_en        = st_q.osc_en[OSC_CORE_EN_BIT];
	assign periph_osc_en      = st_q.osc_en[OSC_PERIPH_EN_BIT];
	assign ps_rdata           = st_q.rdata;
	assign ps_ack             = st_q.ack;
	assign ps_refused         = st_q.refused;

	// Assertions
	a_sec_lock_holds: assert property (@(posedge clock) disable iff (srst)
		clk_en && $past(st_q.security[SEC_WRITE_LOCK]) && $past(clk_en) && !$past(srst)
		|-> st_q.security == $past(st_q.security))
		else $error("security word changed while locked");

	a_osc_reset_zero: assert property (@(posedge clock)
		$past(srst) |-> !core_osc_en && !periph_osc_en)
		else $error("oscillator enables not zero after reset");

	a_osc_write: assert property (@(posedge clock) disable iff (srst)
		clk_en && ps_write && ps_num == REG_RING_OSC_ENABLE && !cfg_jtag_refuse
		|=> {core_osc_en, periph_osc_en} == $past(ps_wdata[1:0]))
		else $error("oscillator control write lost");

	a_boot_read: assert property (@(posedge clock) disable iff (srst)
		clk_en && ps_read && ps_num == REG_TILE_BOOT_STATE && !cfg_jtag_refuse
		|=> ps_rdata[31:24] == 8'h0 && ps_rdata[15:9] == 7'h0 && ps_rdata[7:6] == 2'h0)
		else $error("boot state reserved bits not zero");

	sequence s_dbg_entry;
		clk_en && debug_entry && !(ps_write && ps_debug_mode);
	endsequence
	a_pc_capture: assert property (@(posedge clock) disable iff (srst)
		s_dbg_entry |=> st_q.saved_pc == $past(thread_pc))
		else $error("saved pc not captured");

	a_sp_capture: assert property (@(posedge clock) disable iff (srst)
		s_dbg_entry |=> st_q.saved_sp == $past(thread_sp))
		else $error("saved sp not captured");

	a_status_rsvd: assert property (@(posedge clock) disable iff (srst)
		st_q.saved_status[31:11] == 21'h0 && st_q.saved_status[5] == 1'b0)
		else $error("saved status reserved bits set");

	a_jtag_refuse: assert property (@(posedge clock) disable iff (srst)
		clk_en && ps_read && cfg_jtag_refuse |=> ps_refused && ps_rdata == 32'h0)
		else $error("jtag config access not refused");

	a_ram_size: assert property (@(posedge clock) disable iff (srst)
		clk_en && ps_read && ps_num == REG_RAM_BYTE_SIZE
		|=> ps_rdata[1:0] == 2'h0)
		else $error("ram size low bits set");

	a_ack_follows: assert property (@(posedge clock) disable iff (srst)
		clk_en && (ps_read || ps_write) |=> ps_ack)
		else $error("access not acknowledged");

	a_enable_freeze: assert property (@(posedge clock) disable iff (srst)
		!clk_en |=> $stable(st_q))
		else $error("state moved while clock enable low");

	a_otp_load: assert property (@(posedge clock) disable iff (srst)
		clk_en && otp_sec_valid && !st_q.sec_loaded && !ps_write
		|=> st_q.security == ($past(otp_sec_word) & SEC_WRITABLE_MASK))
		else $error("security word not loaded from otp");

	a_jtag_no_write: assert property (@(posedge clock) disable iff (srst)
		clk_en && ps_write && cfg_jtag_refuse && st_q.sec_loaded
		|=> $stable(st_q.security))
		else $error("refused jtag write changed security word");

	sequence s_plain_write;
		clk_en && ps_write && !ps_debug_mode && !debug_entry;
	endsequence
	a_dbg_write_gate: assert property (@(posedge clock) disable iff (srst)
		s_plain_write |=> $stable(st_q.saved_sp) && $stable(st_q.saved_pc))
		else $error("debug register written outside debug mode");

	a_issue_bit_ro: assert property (@(posedge clock) disable iff (srst)
		clk_en && !debug_entry |=> st_q.saved_status[STATUS_ISSUE_MODE_BIT]
		== $past(st_q.saved_status[STATUS_ISSUE_MODE_BIT]))
		else $error("current issue mode bit written");

endmodule // tile_status_debug_regs

`default_nettype wire

// ===== design/tile_status_pkg.sv
// Constants for the tile processor-status register bank
package tile_status_pkg;

	// Register numbers
	localparam logic [7:0] REG_TILE_BOOT_STATE        = 8'h03;
	localparam logic [7:0] REG_SECURITY_LOCK_CONFIG   = 8'h05;
	localparam logic [7:0] REG_RING_OSC_ENABLE        = 8'h06;
	localparam logic [7:0] REG_RING_COUNT_TILE_CELL   = 8'h07;
	localparam logic [7:0] REG_RING_COUNT_TILE_WIRE   = 8'h08;
	localparam logic [7:0] REG_RING_COUNT_PERIPH_CELL = 8'h09;
	localparam logic [7:0] REG_RING_COUNT_PERIPH_WIRE = 8'h0a;
	localparam logic [7:0] REG_RAM_BYTE_SIZE          = 8'h0c;
	localparam logic [7:0] REG_DEBUG_SAVED_STATUS     = 8'h10;
	localparam logic [7:0] REG_DEBUG_SAVED_PC         = 8'h11;
	localparam logic [7:0] REG_DEBUG_SAVED_STACK_PTR  = 8'h12;
	localparam logic [7:0] REG_DEBUG_FETCH_THREAD_SEL = 8'h13;
	localparam logic [7:0] REG_DEBUG_FETCH_REG_SEL    = 8'h14;

	// Boot status field positions
	localparam int BOOT_PLL_MODE_LSB  = 0;
	localparam int BOOT_FROM_JTAG_BIT = 2;
	localparam int BOOT_FROM_RAM_BIT  = 3;
	localparam int BOOT_NO_OTP_POLL   = 4;
	localparam int BOOT_CORE1_OFF_BIT = 5;
	localparam int BOOT_OVERRIDE_BIT  = 8;
	localparam int BOOT_PROC_NUM_LSB  = 16;

	// Security field positions
	localparam int SEC_JTAG_TAP_OFF  = 0;
	localparam int SEC_JTAG_CFG_OFF  = 4;
	localparam int SEC_OTP_BOOT      = 5;
	localparam int SEC_OTP_REDUND    = 7;
	localparam int SEC_SECTOR_LSB    = 8;
	localparam int SEC_ALL_SECTORS   = 12;
	localparam int SEC_GLOBAL_DBG    = 14;
	localparam int SEC_WRITE_LOCK    = 31;
	localparam logic [31:0] SEC_WRITABLE_MASK = 32'h8000_5fb1;

	// Oscillator control
	localparam int OSC_PERIPH_EN_BIT = 0;
	localparam int OSC_CORE_EN_BIT   = 1;
	localparam logic [1:0] OSC_ENABLE_RESET = 2'h0;
	localparam int OSC_COUNT_W = 16;

	// Debug capture masks
	localparam logic [31:0] SAVED_STATUS_WR_MASK = 32'h0000_06df;
	localparam logic [31:0] SAVED_STATUS_MASK    = 32'h0000_07df;
	localparam int STATUS_ISSUE_MODE_BIT = 8;
	localparam int THREAD_SEL_W = 8;
	localparam int REG_SEL_W    = 5;
	localparam logic [31:0] RAM_SIZE_MASK = 32'hffff_fffc;

	// Ring oscillator settle time before a count may be read
	localparam int OSC_SETTLE_CYCLES = 10;

endpackage

// ===== tb/tile_status_debug_regs_test.sv
// Self-checking bench for the tile processor-status register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module tile_status_debug_regs_test;
	localparam logic [31:0] RAMB = 32'h0002_0000;
	logic        clock, srst, clk_en, ps_read, ps_write, ps_debug_mode, ps_from_jtag;
	logic        ps_ack, ps_refused, otp_sec_valid, debug_entry;
	logic        boot_from_ram, boot_from_jtag, boot_no_otp_poll, core1_powered_off;
	logic        boot_mode_override, otp_lock_all, otp_redundancy_en, otp_force_boot;
	logic        jtag_cfg_block, jtag_tap_block, global_debug_block, core_osc_en, periph_osc_en;
	logic [1:0]  boot_pll_mode_pins;
	logic [3:0]  otp_sector_lock;
	logic [7:0]  ps_num, processor_number;
	logic [31:0] ps_wdata, ps_rdata, otp_sec_word, thread_status, thread_pc, thread_sp;
	logic [31:0] rnd, rd, w, otp, st;
	logic [15:0] cnt [4];
	logic        rf;
	int          miscompares, num_checks;

	tile_status_debug_regs #(.RAM_BYTES(RAMB)) dut (.clock, .srst, .clk_en, .ps_read, .ps_write,
		.ps_num, .ps_wdata, .ps_debug_mode, .ps_from_jtag, .ps_rdata, .ps_ack, .ps_refused,
		.boot_pll_mode_pins, .boot_from_ram, .boot_from_jtag, .boot_no_otp_poll,
		.core1_powered_off, .boot_mode_override, .processor_number, .otp_sec_valid,
		.otp_sec_word, .otp_sector_lock, .otp_lock_all, .otp_redundancy_en, .otp_force_boot,
		.jtag_cfg_block, .jtag_tap_block, .global_debug_block, .core_osc_en, .periph_osc_en,
		.osc_count_tile_cell(cnt[0]), .osc_count_tile_wire(cnt[1]),
		.osc_count_periph_cell(cnt[2]), .osc_count_periph_wire(cnt[3]),
		.debug_entry, .thread_status, .thread_pc, .thread_sp);

	always #5 clock = ~clock;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [31:0] boot_exp();
		return {8'h00, processor_number, 7'h00, boot_mode_override, 2'h0, core1_powered_off,
			boot_no_otp_poll, boot_from_ram, boot_from_jtag, boot_pll_mode_pins};
	endfunction

	function automatic logic [6:0] sec_out(input logic [31:0] s);
		return {s[11:8], s[12], s[7], s[5]};
	endfunction

	task automatic end_sim();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// One access; request held for the single cycle the port takes it
	// access by number
	task automatic acc(input logic wr, input logic [7:0] n, input logic [31:0] d,
		input logic dbg, input logic jt);
		int i;
		@(negedge clock);
		ps_read = !wr; ps_write = wr; ps_num = n; ps_wdata = d;
		ps_debug_mode = dbg; ps_from_jtag = jt;
		@(negedge clock);
		ps_read = 0; ps_write = 0;
		for (i = 0; i < 4 && ps_ack !== 1'b1; i++) @(negedge clock);
		if (ps_ack !== 1'b1) begin
			miscompares++;
			$display("[FAIL] %0t no acknowledge", $time);
			end_sim();
		end
		rd = ps_rdata; rf = ps_refused;
	endtask

	task automatic nxt();
		rnd = lfsr(rnd);
	endtask

	initial begin
		clock = 0; srst = 1; clk_en = 1; ps_read = 0; ps_write = 0; ps_num = 8'h00;
		ps_wdata = 32'h0; ps_debug_mode = 0; ps_from_jtag = 0; debug_entry = 0;
		{processor_number, boot_mode_override, core1_powered_off, boot_no_otp_poll,
			boot_from_ram, boot_from_jtag, boot_pll_mode_pins} = 15'h0;
		thread_status = 32'h0; thread_pc = 32'h0; thread_sp = 32'h0;
		miscompares = 0; num_checks = 0; rnd = 32'ha3110ecd;
		for (int k = 0; k < 4; k++) cnt[k] = 16'h0;
		nxt();
		otp = rnd & 32'h7fff_ffef;
		otp_sec_word = otp; otp_sec_valid = 1;
		repeat (12) @(negedge clock);
		srst = 0;
		acc(0, tile_status_pkg::REG_RING_OSC_ENABLE, 32'h0, 0, 0);
		`CHK({rd, core_osc_en, periph_osc_en}, 34'h0)
		nxt();
		{processor_number, boot_mode_override, core1_powered_off, boot_no_otp_poll,
			boot_from_ram, boot_from_jtag, boot_pll_mode_pins} = rnd[14:0];
		repeat (5) @(negedge clock);
		acc(1, tile_status_pkg::REG_TILE_BOOT_STATE, ~boot_exp(), 1, 0);
		acc(0, tile_status_pkg::REG_TILE_BOOT_STATE, 32'h0, 0, 0);
		`CHK(rd, boot_exp())
		acc(0, tile_status_pkg::REG_SECURITY_LOCK_CONFIG, 32'h0, 0, 0);
		`CHK(rd, otp & tile_status_pkg::SEC_WRITABLE_MASK)
		`CHK(sec_out(otp), {otp_sector_lock, otp_lock_all, otp_redundancy_en, otp_force_boot})
		for (int k = 0; k < 3; k++) begin
			nxt();
			w = (rnd & 32'h7fff_ffff) | ((k == 2) ? 32'h10 : 32'h0);
			acc(1, tile_status_pkg::REG_SECURITY_LOCK_CONFIG, w, 0, 0);
			acc(0, tile_status_pkg::REG_SECURITY_LOCK_CONFIG, 32'h0, 0, 0);
			`CHK(rd, w & tile_status_pkg::SEC_WRITABLE_MASK)
			`CHK({jtag_cfg_block, jtag_tap_block, global_debug_block}, {w[4], w[0], w[14]})
			`CHK({otp_sector_lock, otp_lock_all, otp_redundancy_en, otp_force_boot}, sec_out(w))
		end
		acc(0, tile_status_pkg::REG_TILE_BOOT_STATE, 32'h0, 0, 1);
		`CHK({rf, rd}, 33'h1_0000_0000)
		acc(1, tile_status_pkg::REG_SECURITY_LOCK_CONFIG, 32'h0, 0, 1);
		acc(0, tile_status_pkg::REG_SECURITY_LOCK_CONFIG, 32'h0, 0, 0);
		`CHK(rd, w & tile_status_pkg::SEC_WRITABLE_MASK)
		acc(1, tile_status_pkg::REG_SECURITY_LOCK_CONFIG, w | 32'h8000_0000, 0, 0);
		acc(1, tile_status_pkg::REG_SECURITY_LOCK_CONFIG, ~w, 0, 0);
		acc(0, tile_status_pkg::REG_SECURITY_LOCK_CONFIG, 32'h0, 0, 0);
		`CHK(rd, (w | 32'h8000_0000) & tile_status_pkg::SEC_WRITABLE_MASK)
		for (int k = 3; k >= 0; k--) begin
			nxt();
			acc(1, tile_status_pkg::REG_RING_OSC_ENABLE, {rnd[31:2], 2'(k)}, 0, 0);
			acc(0, tile_status_pkg::REG_RING_OSC_ENABLE, 32'h0, 0, 0);
			`CHK(rd, {30'h0, 2'(k)})
			`CHK({core_osc_en, periph_osc_en}, 2'(k))
		end
		// Clock enable low: request neither taken nor answered
		@(negedge clock);
		clk_en = 0;
		ps_write = 1;
		ps_num = tile_status_pkg::REG_RING_OSC_ENABLE;
		ps_wdata = 32'h3;
		repeat (2) @(negedge clock);
		`CHK({ps_ack, core_osc_en, periph_osc_en}, 3'h0)
		clk_en = 1;
		ps_write = 0;
		for (int k = 0; k < 4; k++) begin
			nxt();
			cnt[k] = rnd[15:0];
		end
		// Counts settle before being read
		repeat (10) @(negedge clock);
		for (int k = 0; k < 4; k++) begin
			acc(0, tile_status_pkg::REG_RING_COUNT_TILE_CELL + 8'(k), 32'h0, 0, 0);
			`CHK(rd, {16'h0, cnt[k]})
		end
		acc(1, tile_status_pkg::REG_RING_OSC_ENABLE, 32'h3, 0, 0);
		srst = 1;
		repeat (2) @(negedge clock);
		srst = 0;
		`CHK({core_osc_en, periph_osc_en}, 2'h0)
		repeat (10) @(negedge clock);
		acc(0, tile_status_pkg::REG_RING_COUNT_PERIPH_WIRE, 32'h0, 0, 0);
		`CHK(rd, {16'h0, cnt[3]})
		acc(0, tile_status_pkg::REG_SECURITY_LOCK_CONFIG, 32'h0, 0, 0);
		`CHK(rd, otp & tile_status_pkg::SEC_WRITABLE_MASK)
		acc(1, tile_status_pkg::REG_RAM_BYTE_SIZE, 32'hffff_ffff, 1, 0);
		acc(0, tile_status_pkg::REG_RAM_BYTE_SIZE, 32'h0, 0, 0);
		`CHK(rd, RAMB & tile_status_pkg::RAM_SIZE_MASK)
		nxt(); st = rnd; thread_status = rnd;
		nxt(); thread_pc = rnd;
		nxt(); thread_sp = rnd;
		@(negedge clock); debug_entry = 1;
		@(negedge clock); debug_entry = 0;
		acc(0, tile_status_pkg::REG_DEBUG_SAVED_STATUS, 32'h0, 0, 0);
		`CHK(rd, st & 32'h0000_07df)
		acc(0, tile_status_pkg::REG_DEBUG_SAVED_PC, 32'h0, 0, 0);
		`CHK(rd, thread_pc)
		acc(1, tile_status_pkg::REG_DEBUG_SAVED_STACK_PTR, ~thread_sp, 0, 0);
		acc(0, tile_status_pkg::REG_DEBUG_SAVED_STACK_PTR, 32'h0, 0, 0);
		`CHK(rd, thread_sp)
		nxt();
		acc(1, tile_status_pkg::REG_DEBUG_SAVED_STATUS, rnd, 1, 0);
		acc(0, tile_status_pkg::REG_DEBUG_SAVED_STATUS, 32'h0, 0, 0);
		`CHK(rd, (rnd & 32'h0000_06df) | (st & 32'h0000_0100))
		acc(1, tile_status_pkg::REG_DEBUG_FETCH_THREAD_SEL, rnd, 1, 0);
		acc(1, tile_status_pkg::REG_DEBUG_FETCH_REG_SEL, ~rnd, 1, 0);
		acc(0, tile_status_pkg::REG_DEBUG_FETCH_THREAD_SEL, 32'h0, 0, 0);
		`CHK(rd, rnd & 32'h0000_00ff)
		acc(0, tile_status_pkg::REG_DEBUG_FETCH_REG_SEL, 32'h0, 0, 0);
		`CHK(rd, ~rnd & 32'h0000_001f)
		acc(1, 8'h04, rnd, 1, 0);
		acc(0, 8'h04, 32'h0, 0, 0);
		`CHK(rd, 32'h0)
		end_sim();
	end
endmodule // tile_status_debug_regs_test
`default_nettype wire
